// File: design/gbsc_top.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module gbsc_top
	import gbsc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [4:0]       port0_pin_out,
	output logic [1:0]       port1_pin_out,
	output logic [6:0]       port2_pin_out
);

	localparam logic [6:0] PORT_MASK [GBSC_NPORT] =
		'{GBSC_P0_MASK, GBSC_P1_MASK, GBSC_P2_MASK};

	logic        bvalid_q;
	logic        bvalid_d;
	logic [1:0]  bresp_q;
	logic [1:0]  bresp_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [1:0]  rresp_q;
	logic [1:0]  rresp_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	logic        wr_fire;
	logic        rd_fire;
	gbsc_reg_t   wsel;
	gbsc_reg_t   rsel;
	logic [6:0]  wfield;
	logic        lane_ok;
	logic [6:0]  lat      [GBSC_NPORT];
	logic        wr_dat   [GBSC_NPORT];
	logic        wr_set   [GBSC_NPORT];
	logic        wr_clr   [GBSC_NPORT];

	// Address and data are taken together in one edge, so there is never
	// more than one write per cycle and order follows the bus.
	assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_awready = s_axi_wvalid && !bvalid_q;
	assign s_axi_wready  = s_axi_awvalid && !bvalid_q;
	assign rd_fire       = s_axi_arvalid && !rvalid_q;
	assign s_axi_arready = !rvalid_q;

	assign wsel    = gbsc_decode(s_axi_awaddr);
	assign rsel    = gbsc_decode(s_axi_araddr);
	assign wfield  = s_axi_wdata[GBSC_FLD_MSB:GBSC_FLD_LSB];
	assign lane_ok = s_axi_wstrb[GBSC_FLD_BYTE];

	always_comb begin
		for (int p = 0; p < GBSC_NPORT; p++) begin
			wr_dat[p] = 1'b0;
			wr_set[p] = 1'b0;
			wr_clr[p] = 1'b0;
		end
		if (wr_fire && lane_ok) begin
			case (wsel)
				GBSC_DAT0: wr_dat[0] = 1'b1;
				GBSC_SET0: wr_set[0] = 1'b1;
				GBSC_CLR0: wr_clr[0] = 1'b1;
				GBSC_DAT1: wr_dat[1] = 1'b1;
				GBSC_SET1: wr_set[1] = 1'b1;
				GBSC_CLR1: wr_clr[1] = 1'b1;
				GBSC_DAT2: wr_dat[2] = 1'b1;
				GBSC_SET2: wr_set[2] = 1'b1;
				GBSC_CLR2: wr_clr[2] = 1'b1;
				default: begin
				end
			endcase
		end
	end

	// Unimplemented and reserved bits are masked off inside each latch.
	for (genvar p = 0; p < GBSC_NPORT; p++) begin : g_port
		gbsc_port_latch #(
			.MASK    (PORT_MASK[p])
		) u_latch (
			.clk_sys (clk_sys),
			.rst_b   (rst_b),
			.wr_dat  (wr_dat[p]),
			.wr_set  (wr_set[p]),
			.wr_clr  (wr_clr[p]),
			.wfield  (wfield),
			.lat_q   (lat[p])
		);
	end

	assign port0_pin_out = lat[0][4:0];
	assign port1_pin_out = lat[1][1:0];
	assign port2_pin_out = lat[2];

	always_comb begin
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (wr_fire) begin
			bvalid_d = 1'b1;
			bresp_d  = (wsel == GBSC_NONE) ? GBSC_RESP_SLV : GBSC_RESP_OKAY;
		end
	end

	// Set and clear registers keep nothing, so they read back as zero.
	always_comb begin
		rvalid_d = rvalid_q;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d  = GBSC_RESP_OKAY;
			rdata_d  = 32'h0;
			case (rsel)
				GBSC_DAT0: rdata_d[GBSC_FLD_MSB:GBSC_FLD_LSB] = lat[0];
				GBSC_DAT1: rdata_d[GBSC_FLD_MSB:GBSC_FLD_LSB] = lat[1];
				GBSC_DAT2: rdata_d[GBSC_FLD_MSB:GBSC_FLD_LSB] = lat[2];
				GBSC_NONE: rresp_d = GBSC_RESP_SLV;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			bvalid_q <= 1'b0;
			bresp_q  <= GBSC_RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q  <= GBSC_RESP_OKAY;
			rdata_q  <= 32'h0;
		end else begin
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q  <= rresp_d;
			rdata_q  <= rdata_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp  = rresp_q;
	assign s_axi_rdata  = rdata_q;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	a_p0_set_high:
	assert property (wr_fire && lane_ok && wsel == GBSC_SET0
		|=> port0_pin_out == ($past(port0_pin_out) | $past(wfield[4:0])))
	else $error("port 0 set write did not raise its pins");

	a_p1_set_high:
	assert property (wr_fire && lane_ok && wsel == GBSC_SET1
		|=> port1_pin_out == ($past(port1_pin_out) | $past(wfield[1:0])))
	else $error("port 1 set write did not raise its pins");

	a_p2_set_high:
	assert property (wr_fire && lane_ok && wsel == GBSC_SET2
		|=> port2_pin_out ==
		(($past(port2_pin_out) | $past(wfield)) & GBSC_P2_MASK))
	else $error("port 2 set write did not raise its pins");

	a_p0_clr_low:
	assert property (wr_fire && lane_ok && wsel == GBSC_CLR0
		|=> port0_pin_out == ($past(port0_pin_out) & ~$past(wfield[4:0])))
	else $error("port 0 clear write did not lower its pins");

	a_p1_clr_low:
	assert property (wr_fire && lane_ok && wsel == GBSC_CLR1
		|=> port1_pin_out == ($past(port1_pin_out) & ~$past(wfield[1:0])))
	else $error("port 1 clear write did not lower its pins");

	a_p2_clr_low:
	assert property (wr_fire && lane_ok && wsel == GBSC_CLR2
		|=> port2_pin_out == ($past(port2_pin_out) & ~$past(wfield)))
	else $error("port 2 clear write did not lower its pins");

	// A data register write of zero is a real write, so it is left out.
	a_pins_hold_still:
	assert property ((!(wr_fire && lane_ok) || (wfield == 7'h0
		&& wsel != GBSC_DAT0 && wsel != GBSC_DAT1 && wsel != GBSC_DAT2))
		|=> $stable(port0_pin_out) && $stable(port1_pin_out)
		&& $stable(port2_pin_out))
	else $error("pins moved without a write of ones");

	a_bresp_mapped:
	assert property (wr_fire && wsel != GBSC_NONE
		|=> s_axi_bvalid && s_axi_bresp == GBSC_RESP_OKAY)
	else $error("mapped write not answered with okay");

	a_bresp_unmapped:
	assert property (wr_fire && wsel == GBSC_NONE
		|=> s_axi_bvalid && s_axi_bresp == GBSC_RESP_SLV)
	else $error("unmapped write not answered with slave error");

	a_wo_reads_zero:
	assert property (rd_fire && (rsel == GBSC_SET1 || rsel == GBSC_CLR2)
		|=> s_axi_rvalid && s_axi_rdata == 32'h0)
	else $error("write-only register returned data");

	a_data_readback:
	assert property (rd_fire && rsel == GBSC_DAT2
		|=> s_axi_rdata[GBSC_FLD_MSB:GBSC_FLD_LSB] == $past(port2_pin_out))
	else $error("data register does not show pin levels");

endmodule

// File: design/gbsc_pkg.sv
package gbsc_pkg;

	localparam int          GBSC_NPORT     = 3;
	localparam int          GBSC_FLD_W     = 7;
	localparam int          GBSC_FLD_LSB   = 16;
	localparam int          GBSC_FLD_MSB   = 22;
	localparam int          GBSC_FLD_BYTE  = 2;

	localparam logic [31:0] GBSC_P0_DAT    = 32'hffff0d20;
	localparam logic [31:0] GBSC_P0_SET    = 32'hffff0d24;
	localparam logic [31:0] GBSC_P0_CLR    = 32'hffff0d28;
	localparam logic [31:0] GBSC_P1_DAT    = 32'hffff0d30;
	localparam logic [31:0] GBSC_P1_SET    = 32'hffff0d34;
	localparam logic [31:0] GBSC_P1_CLR    = 32'hffff0d38;
	localparam logic [31:0] GBSC_P2_DAT    = 32'hffff0d40;
	localparam logic [31:0] GBSC_P2_SET    = 32'hffff0d44;
	localparam logic [31:0] GBSC_P2_CLR    = 32'hffff0d48;

	// Implemented pins within the seven-bit field at bits 22 to 16.
	localparam logic [6:0]  GBSC_P0_MASK   = 7'h1f;
	localparam logic [6:0]  GBSC_P1_MASK   = 7'h03;
	localparam logic [6:0]  GBSC_P2_MASK   = 7'h63;
	localparam logic [6:0]  GBSC_LAT_RST   = 7'h00;

	localparam logic [1:0]  GBSC_RESP_OKAY = 2'h0;
	localparam logic [1:0]  GBSC_RESP_SLV  = 2'h2;

	typedef enum logic [3:0] {
		GBSC_NONE  = 4'h0,
		GBSC_DAT0  = 4'h1,
		GBSC_SET0  = 4'h2,
		GBSC_CLR0  = 4'h3,
		GBSC_DAT1  = 4'h4,
		GBSC_SET1  = 4'h5,
		GBSC_CLR1  = 4'h6,
		GBSC_DAT2  = 4'h7,
		GBSC_SET2  = 4'h8,
		GBSC_CLR2  = 4'h9
	} gbsc_reg_t;

	function automatic gbsc_reg_t gbsc_decode(input logic [31:0] addr);
		case (addr)
			GBSC_P0_DAT: gbsc_decode = GBSC_DAT0;
			GBSC_P0_SET: gbsc_decode = GBSC_SET0;
			GBSC_P0_CLR: gbsc_decode = GBSC_CLR0;
			GBSC_P1_DAT: gbsc_decode = GBSC_DAT1;
			GBSC_P1_SET: gbsc_decode = GBSC_SET1;
			GBSC_P1_CLR: gbsc_decode = GBSC_CLR1;
			GBSC_P2_DAT: gbsc_decode = GBSC_DAT2;
			GBSC_P2_SET: gbsc_decode = GBSC_SET2;
			GBSC_P2_CLR: gbsc_decode = GBSC_CLR2;
			default:     gbsc_decode = GBSC_NONE;
		endcase
	endfunction

endpackage

// File: design/gbsc_port_latch.sv
`timescale 1ns/1ps
module gbsc_port_latch
	import gbsc_pkg::*;
#(
	parameter logic [6:0] MASK = 7'h7f
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       wr_dat,
	input  wire logic       wr_set,
	input  wire logic       wr_clr,
	input  wire logic [6:0] wfield,
	output logic      [6:0] lat_q
);

	logic [6:0] lat_d;

	// On set and clear writes only bits written as one move a pin; a data write loads every field bit in MASK, zeros included.
	always_comb begin
		lat_d = lat_q;
		if (wr_dat) begin
			lat_d = wfield;
		end
		if (wr_set) begin
			lat_d = lat_d | wfield;
		end
		if (wr_clr) begin
			lat_d = lat_d & ~wfield;
		end
		lat_d = lat_d & MASK;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lat_q <= GBSC_LAT_RST;
		end else begin
			lat_q <= lat_d;
		end
	end

endmodule

// File: verification/gbsc_pin_load.sv
`timescale 1ns/1ps
module gbsc_pin_load (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic [4:0] pin0,
	input  wire logic [1:0] pin1,
	input  wire logic [6:0] pin2,
	output int              n_toggle
);
	logic [13:0] last_q;

	// Counts every pin edge, so a stray change on an untouched pin shows up.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			last_q <= '0;
			n_toggle <= 0;
		end else begin
			last_q <= {pin0, pin1, pin2};
			n_toggle <= n_toggle + $countones({pin0, pin1, pin2} ^ last_q);
		end
	end
endmodule

// File: verification/test_gbsc_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
 n_fail++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module test_gbsc_top;
	import gbsc_pkg::*;
	logic        clk_sys = 0, rst_b = 0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0;
	logic        rready = 1, awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp, eb;
	logic [4:0]  p0, e0 = '0;
	logic [1:0]  p1, e1 = '0;
	logic [6:0]  p2, e2 = '0;
	int          n_fail = 0, checked = 0, ntog, etog = 0;
	logic [31:0] ta[13], td[13];
	logic [3:0]  ts[13];

	gbsc_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.port0_pin_out(p0), .port1_pin_out(p1), .port2_pin_out(p2));
	gbsc_pin_load i_load (.clk_sys(clk_sys), .rst_b(rst_b), .pin0(p0),
		.pin1(p1), .pin2(p2), .n_toggle(ntog));

	always #20 clk_sys = ~clk_sys;

	// Ready lines stay high, so the next request may start at the answer edge.
	// Only the watchdog ends a wait that never gets its answer.
	task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
		logic aw, w;
		aw = 1;
		w = 1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		forever begin
			@(posedge clk_sys);
			if (!aw && !w && bvalid === 1'b1) break;
			if (aw && awready === 1'b1) begin
				aw = 0;
				awvalid <= 0;
			end
			if (w && wready === 1'b1) begin
				w = 0;
				wvalid <= 0;
			end
		end
		rsp = bresp;
	endtask

	task automatic rd(input logic [31:0] a);
		logic ar;
		ar = 1;
		araddr <= a;
		arvalid <= 1;
		forever begin
			@(posedge clk_sys);
			if (!ar && rvalid === 1'b1) break;
			if (ar && arready === 1'b1) begin
				ar = 0;
				arvalid <= 0;
			end
		end
		rsp = rresp;
	endtask

	task automatic apply(input logic [31:0] a, d, input logic [3:0] s);
		logic [13:0] old;
		old = {e0, e1, e2};
		if (s[2]) begin
			case (a)
				GBSC_P0_SET: e0 = e0 | d[20:16];
				GBSC_P0_CLR: e0 = e0 & ~d[20:16];
				GBSC_P1_SET: e1 = e1 | d[17:16];
				GBSC_P1_CLR: e1 = e1 & ~d[17:16];
				GBSC_P2_SET: e2 = e2 | (d[22:16] & 7'h63);
				GBSC_P2_CLR: e2 = e2 & ~(d[22:16] & 7'h63);
				GBSC_P0_DAT: e0 = d[20:16];
				GBSC_P1_DAT: e1 = d[17:16];
				GBSC_P2_DAT: e2 = d[22:16] & 7'h63;
				default: ;
			endcase
		end
		etog += $countones(old ^ {e0, e1, e2});
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#(40 * 3000);
		n_fail++;
		end_of_test();
	end

	initial begin
		// Reserved bits are written as zero throughout.
		ta = '{GBSC_P0_SET, GBSC_P0_CLR, GBSC_P1_SET, GBSC_P1_SET,
			GBSC_P1_CLR, GBSC_P2_SET, GBSC_P2_CLR, GBSC_P2_SET, GBSC_P2_SET,
			32'hffff0d2c, GBSC_P0_CLR, GBSC_P1_CLR, GBSC_P2_CLR};
		td = '{32'h001f0000, 32'h00050000, 32'h00020000, 32'h00010000,
			32'h00020000, 32'h00630000, 32'h00410000, 32'h00000000,
			32'h00410000, 32'h001f0000, 32'h001f0000, 32'h00030000,
			32'h00630000};
		ts = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hb,
			4'hf, 4'hf, 4'hf, 4'hf};
		repeat (6) @(posedge clk_sys);
		rst_b <= 1;
		@(posedge clk_sys);
		`CHK("pins_rst", 14'h0, {p0, p1, p2})
		$display("reset test done");
		for (int i = 0; i < 13; i++) begin
			wr(ta[i], td[i], ts[i]);
			apply(ta[i], td[i], ts[i]);
			eb = (ta[i] == 32'hffff0d2c) ? GBSC_RESP_SLV : GBSC_RESP_OKAY;
			`CHK("bresp", eb, rsp)
			`CHK("pin0", e0, p0)
			`CHK("pin1", e1, p1)
			`CHK("pin2", e2, p2)
		end
		repeat (3) @(posedge clk_sys);
		`CHK("toggles", etog, ntog)
		$display("set and clear test done");
		for (int i = 0; i < 4; i++) begin
			rd(i == 3 ? 32'hffff0d00 : ta[i * 5 + 1]);
			`CHK("rdata", 32'h0, rdata)
			`CHK("rresp", i == 3 ? GBSC_RESP_SLV : GBSC_RESP_OKAY, rsp)
		end
		$display("read test done");
		wr(GBSC_P2_DAT, 32'h00220000, 4'h4);
		apply(GBSC_P2_DAT, 32'h00220000, 4'h4);
		`CHK("bresp_dat", GBSC_RESP_OKAY, rsp)
		`CHK("pin2_dat", e2, p2)
		rd(GBSC_P0_DAT);
		`CHK("rd_dat0", {11'h0, e0, 16'h0}, rdata)
		rd(GBSC_P1_DAT);
		`CHK("rd_dat1", {14'h0, e1, 16'h0}, rdata)
		rd(GBSC_P2_DAT);
		`CHK("rd_dat2", {9'h0, e2, 16'h0}, rdata)
		$display("data register test done");
		end_of_test();
	end
endmodule
